// >>> tcp_pkg.sv
// Package for the capture, square-wave and pulse-generator timer block.
// Assumes a single 25 MHz clock. All control fields arrive as plain ports.
package tcp_pkg;

    // ********************************************************************
    // Field positions and codes
    // ********************************************************************
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CAPTURE_RESET = 16'h0000;

    // Prescaler select: clock field in bits 1:0, edge field in bits 5:4.
    localparam int PRESC_CLK_LSB = 0;
    localparam int PRESC_EDGE_LSB = 4;

    // Edge select codes.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Count clock dividers for clock codes 0..3 (division ratios).
    localparam int DIV_CODE0 = 1;
    localparam int DIV_CODE1 = 4;
    localparam int DIV_CODE2 = 16;
    localparam int DIV_CODE3 = 64;
    localparam int PRE_W = 6;

    // Output control: enable bit 0, toggle-on-match-A bit 1,
    // toggle-on-match-B bit 4, initial level field bits 3:2.
    localparam int OUT_EN_BIT = 0;
    localparam int OUT_TOG_A_BIT = 1;
    localparam int OUT_LVL_LSB = 2;
    localparam int OUT_TOG_B_BIT = 4;
    localparam logic [1:0] LVL_KEEP = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic OUT_IDLE_LEVEL = 1'b0;

    // Operating modes of the block.
    typedef enum logic [4:0] {
        TCP_STOP = 5'b00001,
        TCP_FREE_RUN = 5'b00010,
        TCP_RESTART = 5'b00100,
        TCP_SQUARE = 5'b01000,
        TCP_PPG = 5'b10000
    } tcp_mode_e;

    // Control bundle from software.
    typedef struct packed {
        tcp_mode_e mode;
        logic [7:0] presc;
        logic [7:0] out_ctrl;
        logic capture_source;
        logic [CNT_W-1:0] cmp_a;
        logic [CNT_W-1:0] cmp_b;
    } tcp_ctrl_s;

    // Status bundle back to software.
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] cap_a;
        logic [CNT_W-1:0] cap_b;
        logic overflow;
        logic irq_a;
        logic irq_b;
    } tcp_stat_s;

endpackage

// >>> tcp_edge_filter.sv
// Two-sample edge detector for one trigger pin.
// Assumes the pin is synchronous to ref_clk_in and the enable is a pulse.
`timescale 1ns/10ps

module tcp_edge_filter (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Sampling enable and pin.
    input wire logic sample_en_in,
    input wire logic pin_in,
    // Edge select code.
    input wire logic [1:0] edge_sel_in,
    // One-cycle pulse on a confirmed valid edge, plus confirmed level.
    output logic edge_out,
    output logic rise_out,
    output logic level_out
);

    logic [1:0] samples;
    logic next_level;
    logic rise;
    logic fall;

    // A level only counts after two equal samples, rejecting short noise.
    assign next_level = (samples[0] == samples[1]) ? samples[0] : level_out;
    assign rise = sample_en_in & next_level & ~level_out;
    assign fall = sample_en_in & ~next_level & level_out;

    // Shift the pin in at each count clock.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            samples <= 2'h0;
        end else if (sample_en_in) begin
            samples <= {samples[0], pin_in};
        end
    end

    // Confirmed level and edge pulses.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= 1'b0;
            edge_out <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            if (sample_en_in) begin
                level_out <= next_level;
            end
            rise_out <= rise;
            case (edge_sel_in)
                tcp_pkg::EDGE_FALL: edge_out <= fall;
                tcp_pkg::EDGE_RISE: edge_out <= rise;
                tcp_pkg::EDGE_BOTH: edge_out <= rise | fall;
                default: edge_out <= 1'b0;
            endcase
        end
    end

endmodule // tcp_edge_filter

// >>> tcp_timer.sv
// Top of the 16-bit capture/compare timer: capture, square wave and PPG.
// Assumes software writes control fields only while mode is TCP_STOP.
// Trigger pins are taken as synchronous; no metastability guard is built in.
// Widths beyond one counter cycle alias, since wraps are not counted.
//
// Overview of operation
// - Free-run: pin A edge captures B, irq B.
// - Free-run: opposite pin A edge captures A.
// - Pin A valid edge from edge field.
// - Capture only after two equal samples.
// - Both-edge select blocks pin A capture into A.
// - Source bit set: pin B raises irq A only.
// - Restart: capture B, then clear counter.
// - Restart mode supports rising or falling.
// - Overflow flag set on counter wrap.
// - Square wave toggles every compare A plus one.
// - Square mode clears counter on compare A.
// - PPG: period from A, width from B.
// - PPG toggles flip-flop on A and B.
// - PPG period A plus one, width B plus one.
// - Count clock from low prescaler bits.
`timescale 1ns/10ps

module tcp_timer (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Software control bundle.
    input wire tcp_pkg::tcp_ctrl_s ctrl_in,
    // One-cycle pulse clearing the overflow flag.
    input wire logic overflow_clear_in,
    // Trigger pins.
    input wire logic trigger_input_a_in,
    input wire logic trigger_input_b_in,
    // Status to software.
    output tcp_pkg::tcp_stat_s status_out,
    // Waveform pin.
    output logic waveform_output_pin_out
);

    // ********************************************************************
    // Count clock divider
    // ********************************************************************

    logic [tcp_pkg::PRE_W-1:0] pre_cnt;
    logic [1:0] clk_sel;
    logic [1:0] edge_sel;
    logic count_en;
    logic running;

    assign clk_sel = ctrl_in.presc[tcp_pkg::PRESC_CLK_LSB +: 2];
    assign edge_sel = ctrl_in.presc[tcp_pkg::PRESC_EDGE_LSB +: 2];
    assign running = (ctrl_in.mode != tcp_pkg::TCP_STOP);

    // Terminal count of the divider for the selected ratio.
    function automatic logic [tcp_pkg::PRE_W-1:0] div_last(
        input logic [1:0] sel
    );
        case (sel)
            2'h0: div_last = tcp_pkg::PRE_W'(tcp_pkg::DIV_CODE0 - 1);
            2'h1: div_last = tcp_pkg::PRE_W'(tcp_pkg::DIV_CODE1 - 1);
            2'h2: div_last = tcp_pkg::PRE_W'(tcp_pkg::DIV_CODE2 - 1);
            default: div_last = tcp_pkg::PRE_W'(tcp_pkg::DIV_CODE3 - 1);
        endcase
    endfunction

    // One enable pulse per divided period; all counting keys off this pulse.
    assign count_en = running && (pre_cnt == div_last(clk_sel));

    // Divider restarts while stopped so the first count is one full period.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_cnt <= '0;
        end else if (!running || count_en) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // ********************************************************************
    // Input edge filters
    // ********************************************************************

    logic edge_a;
    logic rise_a;
    logic edge_b;
    logic level_a;

    // Each filter adds the same fixed latency to every edge, so widths taken
    // as the difference of two captures are not biased by it.
    tcp_edge_filter u_filt_a (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .sample_en_in(count_en),
        .pin_in(trigger_input_a_in),
        .edge_sel_in(edge_sel),
        .edge_out(edge_a),
        .rise_out(rise_a),
        .level_out(level_a)
    );

    // Pin B shares the pin A edge field; no separate field is modelled.
    tcp_edge_filter u_filt_b (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .sample_en_in(count_en),
        .pin_in(trigger_input_b_in),
        .edge_sel_in(edge_sel),
        .edge_out(edge_b),
        .rise_out(),
        .level_out()
    );

    // Opposite edge of pin A, used for capture into A in free-run mode.
    logic opp_a;
    logic level_a_q;
    logic edge_chg;

    // Opposite edge is a confirmed transition that was not the valid one.
    // Both-edge select leaves no opposite edge, so pin A never captures into A.
    always_comb begin
        case (edge_sel)
            tcp_pkg::EDGE_RISE: opp_a = edge_chg & ~rise_a;
            tcp_pkg::EDGE_FALL: opp_a = edge_chg & rise_a;
            default: opp_a = 1'b0;
        endcase
    end

    // Any confirmed change of pin A, delayed to line up with edge_a.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_a_q <= 1'b0;
        end else begin
            level_a_q <= level_a;
        end
    end
    assign edge_chg = level_a ^ level_a_q;

    // ********************************************************************
    // Counter and overflow
    // ********************************************************************

    logic [tcp_pkg::CNT_W-1:0] count;
    logic match_a;
    logic match_b;
    logic is_free;
    logic is_restart;
    logic is_square;
    logic is_ppg;

    assign is_free = (ctrl_in.mode == tcp_pkg::TCP_FREE_RUN);
    assign is_restart = (ctrl_in.mode == tcp_pkg::TCP_RESTART);
    assign is_square = (ctrl_in.mode == tcp_pkg::TCP_SQUARE);
    assign is_ppg = (ctrl_in.mode == tcp_pkg::TCP_PPG);
    // Matches only count on an enable pulse, so a slow count clock gives one
    // event per compare rather than one per fast clock.
    assign match_a = count_en && (count == ctrl_in.cmp_a);
    assign match_b = count_en && (count == ctrl_in.cmp_b);

    // Counting stops and clears in stop mode.
    // Restart clears on the capture pulse itself, so the next width starts
    // from zero and the captured value is the whole previous width, except at clock code 0 where it is one count less.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= tcp_pkg::CNT_RESET;
        end else if (!running) begin
            count <= tcp_pkg::CNT_RESET;
        end else if (is_restart && edge_a) begin
            count <= tcp_pkg::CNT_RESET;
        end else if (count_en) begin
            if ((is_square || is_ppg) && count == ctrl_in.cmp_a) begin
                count <= tcp_pkg::CNT_RESET;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    // Overflow flag: a wrap in the same cycle as a clear wins.
    // The flag is sticky so that a late read by software still sees a wrap.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_out.overflow <= 1'b0;
        end else if (count_en && count == tcp_pkg::CNT_MAX) begin
            status_out.overflow <= 1'b1;
        end else if (overflow_clear_in) begin
            status_out.overflow <= 1'b0;
        end
    end

    // ********************************************************************
    // Captures and interrupt pulses
    // ********************************************************************

    // Both captures read the counter in the cycle of the edge pulse, so the
    // difference of two captures is an exact width in count clocks.
    logic measure;
    assign measure = is_free || is_restart;

    // Capture B on pin A valid edge in both measurement modes.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_out.cap_b <= tcp_pkg::CAPTURE_RESET;
        end else if (measure && edge_a) begin
            status_out.cap_b <= count;
        end
    end

    // Capture A on pin A opposite edge in free-run, or on pin B unless source bit set.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_out.cap_a <= tcp_pkg::CAPTURE_RESET;
        end else if (is_free && opp_a) begin
            status_out.cap_a <= count;
        end else if (measure && edge_b && !ctrl_in.capture_source) begin
            status_out.cap_a <= count;
        end
    end

    logic cap_irq_a;
    logic cap_irq_b;
    logic cmp_irq_a;
    logic cmp_irq_b;

    // Capture sources follow the filtered edges, compare sources the matches.
    // Only one kind is live in a mode, so the or never merges two events.
    assign cap_irq_a = measure && edge_b;
    assign cap_irq_b = measure && edge_a;
    assign cmp_irq_a = (is_square || is_ppg) && match_a;
    assign cmp_irq_b = is_ppg && match_b;

    // Interrupt pulses, one cycle each.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_out.irq_a <= 1'b0;
            status_out.irq_b <= 1'b0;
        end else begin
            status_out.irq_a <= cap_irq_a || cmp_irq_a;
            status_out.irq_b <= cap_irq_b || cmp_irq_b;
        end
    end

    // Counter mirrored to status from a register.
    // Software sees the count one clock late; captures use the live value.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_out.count <= tcp_pkg::CNT_RESET;
        end else begin
            status_out.count <= count;
        end
    end

    // ********************************************************************
    // Output flip-flop and pin
    // ********************************************************************

    logic out_ff;
    logic out_en;
    logic tog_a;
    logic tog_b;
    logic [1:0] lvl;

    assign out_en = ctrl_in.out_ctrl[tcp_pkg::OUT_EN_BIT];
    assign tog_a = ctrl_in.out_ctrl[tcp_pkg::OUT_TOG_A_BIT];
    assign tog_b = ctrl_in.out_ctrl[tcp_pkg::OUT_TOG_B_BIT];
    assign lvl = ctrl_in.out_ctrl[tcp_pkg::OUT_LVL_LSB +: 2];

    // Level field presets the flip-flop while stopped; code 11 is ignored.
    // A level change while running has no effect; the preset is applied in
    // stop mode only, which keeps the waveform free of stray edges.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_ff <= tcp_pkg::OUT_IDLE_LEVEL;
        end else if (!running) begin
            if (lvl == tcp_pkg::LVL_LOW) begin
                out_ff <= 1'b0;
            end else if (lvl == tcp_pkg::LVL_HIGH) begin
                out_ff <= 1'b1;
            end
        end else if ((tog_a && match_a && (is_square || is_ppg))
                     || (tog_b && match_b && is_ppg)) begin
            out_ff <= ~out_ff;
        end
    end

    // Pin shows the flip-flop only while enabled, one cycle later.
    // The extra register costs one clock of lag but keeps the pin glitch-free.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            waveform_output_pin_out <= tcp_pkg::OUT_IDLE_LEVEL;
        end else begin
            waveform_output_pin_out <= out_en ? out_ff
                                              : tcp_pkg::OUT_IDLE_LEVEL;
        end
    end

endmodule // tcp_timer

// >>> tcp_timer_chk.sv
// Assertion checker for the capture, square-wave and PPG timer.
// Assumes a bind to tcp_timer, one clock and an async high reset.
`timescale 1ns/10ps

module tcp_timer_chk (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Timer inputs.
    input wire tcp_pkg::tcp_ctrl_s ctrl_in,
    input wire logic overflow_clear_in,
    // Timer outputs.
    input wire tcp_pkg::tcp_stat_s status_out,
    input wire logic waveform_output_pin_out
);
    // **********
    // Properties
    // **********
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // Mode decodes; div1 means a count enable on every clock.
    logic fr, rs, sq, pg, div1;
    assign fr = ctrl_in.mode == tcp_pkg::TCP_FREE_RUN;
    assign rs = ctrl_in.mode == tcp_pkg::TCP_RESTART;
    assign sq = ctrl_in.mode == tcp_pkg::TCP_SQUARE;
    assign pg = ctrl_in.mode == tcp_pkg::TCP_PPG;
    assign div1 = ctrl_in.presc[1:0] == 2'h0;

    // Four cycles of run skip the clear made on leaving stop.
    a_count_step: assert property (
        (fr && div1) [*4] |->
        status_out.count - $past(status_out.count) == 16'h1)
        else $error("Counter did not step by one.");
    a_ovf_set: assert property (
        fr && $past(fr) && $past(status_out.count) == 16'hffff &&
        status_out.count == 16'h0 |-> ##[0:2] status_out.overflow)
        else $error("Overflow flag missed a wrap.");
    a_ovf_sticky: assert property (
        status_out.overflow && !overflow_clear_in |=> status_out.overflow)
        else $error("Overflow flag dropped by itself.");
    a_irq_once: assert property (
        status_out.irq_b |=> !status_out.irq_b)
        else $error("Capture interrupt longer than one cycle.");
    a_capb_irq: assert property (
        $changed(status_out.cap_b) && ctrl_in.mode == $past(ctrl_in.mode)
        |-> status_out.irq_b)
        else $error("Capture B loaded without its interrupt.");
    a_both_noa: assert property (
        (fr && ctrl_in.presc[5:4] == tcp_pkg::EDGE_BOTH &&
        ctrl_in.capture_source) [*2] |-> $stable(status_out.cap_a))
        else $error("Capture A loaded while blocked.");
    a_sq_clear: assert property (
        sq [*3] |-> status_out.count <= ctrl_in.cmp_a)
        else $error("Square counter passed compare A.");
    a_ppg_bound: assert property (
        pg [*3] |-> status_out.count <= ctrl_in.cmp_a)
        else $error("Pulse counter passed compare A.");
    a_out_idle: assert property (
        (!ctrl_in.out_ctrl[tcp_pkg::OUT_EN_BIT]) [*2] |->
        waveform_output_pin_out == tcp_pkg::OUT_IDLE_LEVEL)
        else $error("Output pin active while disabled.");
    a_restart_clr: assert property (
        $rose(status_out.irq_b) && rs && div1 |->
        ##[0:3] status_out.count < 16'h2)
        else $error("Counter not restarted after capture.");
endmodule // tcp_timer_chk

bind tcp_timer tcp_timer_chk chk (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ctrl_in(ctrl_in),
    .overflow_clear_in(overflow_clear_in),
    .status_out(status_out),
    .waveform_output_pin_out(waveform_output_pin_out)
);

// >>> tcp_pulse_src.sv
// Model of the pulse sources on the two trigger pins.
// Assumes the timer samples both pins on ref_clk_in.
`timescale 1ns/10ps

module tcp_pulse_src (
    // Clock.
    input wire logic ref_clk_in,
    // Trigger pins.
    output logic trig_a_out,
    output logic trig_b_out
);
    // **********
    // Pulse driver
    // **********
    // Both pins rest low between bursts, as an idle source would.
    initial begin
        trig_a_out = 1'b0;
        trig_b_out = 1'b0;
    end

    // Holds one pin at a level for len clocks, changed just after an edge.
    task automatic drive(input logic sel, input logic v, input int len);
        @(posedge ref_clk_in);
        #1;
        if (sel) begin
            trig_b_out = v;
        end else begin
            trig_a_out = v;
        end
        repeat (len - 1) @(posedge ref_clk_in);
    endtask

    // Widths stay far below a counter cycle; overflows are not counted.
    task automatic burst(input logic sel, input int hi, input int lo,
                         input int n);
        repeat (n) begin
            drive(sel, 1'b1, hi);
            drive(sel, 1'b0, lo);
        end
        #3;
    endtask
endmodule // tcp_pulse_src

// >>> tcp_timer_tb_top.sv
// Self-checking testbench for the capture, square-wave and PPG timer.
// Assumes the timer, its checker and the pulse source are compiled.
`timescale 1ns/10ps

module tcp_timer_tb_top;
    // **********
    // Signals
    // **********
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ovf_clr = 1'b0;
    logic pin;
    logic pin_d = 1'b0;
    logic trig_a;
    logic trig_b;
    logic ok;
    tcp_pkg::tcp_ctrl_s ctrl;
    tcp_pkg::tcp_stat_s st;
    logic [15:0] exp_q[$];
    logic [15:0] prev_b;
    logic [15:0] cap_keep;
    int fail_count = 0;
    int samples_checked = 0;
    int kind = 0;
    int seen_a = 0;
    int seen_b = 0;
    int cyc = 0;
    int tg = 0;
    int t_edge = 0;
    int t_rise = 0;
    int hi_len = 0;
    int lo_len = 0;
    int ca = 0;
    int cb = 0;
    int div;
    int h;

    // Clock at 25 MHz.
    always #20 ref_clk_in = ~ref_clk_in;

    tcp_timer dut (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ctrl_in(ctrl),
        .overflow_clear_in(ovf_clr),
        .trigger_input_a_in(trig_a),
        .trigger_input_b_in(trig_b),
        .status_out(st),
        .waveform_output_pin_out(pin)
    );

    tcp_pulse_src src (
        .ref_clk_in(ref_clk_in),
        .trig_a_out(trig_a),
        .trig_b_out(trig_b)
    );

    // **********
    // Tasks
    // **********
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A result with no note waiting is itself a mismatch.
    task automatic pop(input logic [15:0] got);
        if (exp_q.size() == 0) check(got, ~got);
        else check(got, exp_q.pop_front());
    endtask

    // Waits, bounded, until every noted result has been seen.
    task automatic drain();
        for (int i = 0; i < 1000 && exp_q.size() > 0; i++)
            @(posedge ref_clk_in);
        #3;
        if (exp_q.size() > 0) begin
            fail_count++;
            $display("ERROR %0t: expected result missing", $time);
            test_done();
        end
        kind = 0;
    endtask

    // Controls change only in stop mode, so each scenario halts first.
    task automatic halt();
        @(posedge ref_clk_in);
        #1 ctrl.mode = tcp_pkg::TCP_STOP;
        @(posedge ref_clk_in);
        #1;
    endtask

    // The mode is written last, which starts the counter.
    task automatic go(input tcp_pkg::tcp_mode_e m, input int k);
        @(posedge ref_clk_in);
        #1;
        kind = k;
        seen_a = 0;
        seen_b = 0;
        tg = 0;
        t_rise = 0;
        ctrl.mode = m;
    endtask

    // Result watcher: samples settled outputs just after each edge.
    always @(posedge ref_clk_in) begin
        #2;
        cyc++;
        if (st.irq_a === 1'b1) seen_a++;
        if (st.irq_b === 1'b1) begin
            if (kind == 1 && seen_b > 0) pop(st.cap_a - prev_b);
            if (kind == 2 && seen_b > 1) pop(st.cap_b - prev_b);
            prev_b = st.cap_b;
            seen_b++;
        end
        if (pin !== pin_d && kind > 2) begin
            tg++;
            if (pin === 1'b1) lo_len = cyc - t_edge;
            if (pin === 1'b0) hi_len = cyc - t_edge;
            ok = (hi_len == cb + 1) || (lo_len == cb + 1);
            if (kind == 3 && tg > 2) pop(16'(cyc - t_edge));
            if (kind == 4 && pin === 1'b1 && t_rise > 0) begin
                pop(16'(cyc - t_rise));
                check(16'(ok), 16'h1);
            end
            if (pin === 1'b1) t_rise = cyc;
            t_edge = cyc;
        end
        pin_d = pin;
    end

    // **********
    // Scenarios
    // **********
    initial begin
        ctrl = '0;
        ctrl.mode = tcp_pkg::TCP_STOP;
        void'($urandom(32'h8c5c));
        repeat (2) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        // Widths on every count clock, with rising and falling select.
        for (int c = 0; c < 4; c++) begin
            for (int e = 0; e < 2; e++) begin
                div = (c == 0) ? tcp_pkg::DIV_CODE0 : (c == 1) ?
                      tcp_pkg::DIV_CODE1 : (c == 2) ? tcp_pkg::DIV_CODE2 :
                      tcp_pkg::DIV_CODE3;
                h = 2 + $urandom % 4;
                halt();
                ctrl.presc = {2'h0, e[1:0], 2'h0, c[1:0]};
                repeat (2) exp_q.push_back(16'((e == 1) ? h : 3));
                go(tcp_pkg::TCP_FREE_RUN, 1);
                src.burst(1'b0, h * div, 3 * div, 3);
                drain();
            end
        end
        // Restart capture repeats the same period on either edge.
        for (int e = 0; e < 2; e++) begin
            halt();
            ctrl.presc = {2'h0, e[1:0], 4'h0};
            repeat (2) exp_q.push_back(16'h0);
            go(tcp_pkg::TCP_RESTART, 2);
            src.burst(1'b0, 3, 4 + e, 4);
            drain();
        end
        // A one-clock glitch is dropped, a two-clock pulse is taken.
        halt();
        ctrl.presc = 8'h10;
        go(tcp_pkg::TCP_FREE_RUN, 0);
        src.burst(1'b0, 1, 4, 3);
        check(16'(seen_b), 16'h0);
        src.burst(1'b0, 2, 4, 1);
        check(16'(seen_b), 16'h1);
        // Both edges on pin A, pin B as an interrupt-only source.
        halt();
        ctrl.presc = 8'h30;
        ctrl.capture_source = 1'b1;
        go(tcp_pkg::TCP_FREE_RUN, 0);
        cap_keep = st.cap_a;
        src.burst(1'b0, 3, 3, 2);
        src.burst(1'b1, 3, 3, 2);
        repeat (4) @(posedge ref_clk_in);
        #3;
        check(16'(seen_b), 16'h4);
        check(16'(seen_a), 16'h4);
        check(st.cap_a, cap_keep);
        // Square wave with a random nonzero compare value.
        halt();
        ca = 3 + $urandom % 40;
        ctrl.presc = 8'h00;
        ctrl.capture_source = 1'b0;
        ctrl.out_ctrl = 8'h07;
        ctrl.cmp_a = 16'(ca);
        repeat (4) exp_q.push_back(16'(ca + 1));
        go(tcp_pkg::TCP_SQUARE, 3);
        drain();
        // With the enable bit clear the pin stays idle.
        halt();
        ctrl.out_ctrl = 8'h06;
        go(tcp_pkg::TCP_SQUARE, 0);
        repeat (3 * ca) @(posedge ref_clk_in);
        #3;
        check({15'h0, pin}, 16'h0);
        // Pulse generator, low start level, both toggles on.
        halt();
        ca = 20 + $urandom % 40;
        cb = 1 + $urandom % (ca - 1);
        ctrl.cmp_a = 16'(ca);
        ctrl.cmp_b = 16'(cb);
        ctrl.out_ctrl = 8'h17;
        repeat (3) exp_q.push_back(16'(ca + 1));
        go(tcp_pkg::TCP_PPG, 4);
        drain();
        // Free run until the counter wraps, then clear the flag.
        halt();
        ctrl.out_ctrl = 8'h00;
        go(tcp_pkg::TCP_FREE_RUN, 0);
        for (int i = 0; i < 70000 && st.overflow !== 1'b1; i++)
            @(posedge ref_clk_in);
        check({15'h0, st.overflow}, 16'h1);
        if (st.overflow !== 1'b1) test_done();
        #1 ovf_clr = 1'b1;
        @(posedge ref_clk_in);
        #1 ovf_clr = 1'b0;
        @(posedge ref_clk_in);
        #3;
        check({15'h0, st.overflow}, 16'h0);
        test_done();
    end
endmodule // tcp_timer_tb_top
